//--- dsmc_core.sv
// What this block does
// R1 - Four modes, two independent channels.
// R2 - Wake by reset pin or input activity.
// R3 - Wake resets registers, enters Normal, settles.
// R4 - Normal flag only wake, no failsafe, no fault.
// R5 - Target state equation per channel.
// R6 - Duty term from pulse-width bits 7..0.
// R7 - Direct mode uses default delay, slew 00.
// R8 - Internal clock bit selects internal clocking.
// R9 - External clock sets frequency, rest programmable.
// R10 - PWM up to 1 kHz, either source.
// R11 - Per-channel pulse-width, setup, limit registers.
// R12 - Rising reset pin or input enters Normal.
// R13 - Host toggles keepalive every 310 ms.
// R14 - Keepalive timeout or supply loss: Fail-safe.
// R15 - Watchdog disable bit suppresses timeout Fail-safe.
// R16 - Activity flag drops after 250 ms idle.
// R17 - Both flags low, reset low: Sleep.
// R18 - Reset low or Fail-safe: direct inputs only.
// R19 - Host keeps reset high below 4 Hz.
// R20 - Status shows per-channel on and fault.
// R21 - Fail-safe: indicator low, registers cleared.
// R22 - Exit Fail-safe: keepalive 1, then word.
// R23 - Fault in Fail-safe keeps registers reset.
// R24 - Pins synchronised before edges and timers.
// R25 - Mode priority Sleep, Fault, Fail-safe, Normal.
//
// Purpose: Operating mode sequencing and channel target computation.
// Assumes: SPI framing lives outside; each received word arrives as a one-cycle strobe.
// Notes: Register contents arrive as ports and are gated here while they must read as reset.
`timescale 1ns/10ps
module dsmc_core
  import dsmc_pkg::*;
#(
  parameter int unsigned KeepaliveCycles = KEEPALIVE_TIMEOUT_CYC,
  parameter int unsigned IdleCycles = INPUT_IDLE_CYC
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Pins from the host
  input wire logic wake_reset_pin,
  input wire logic [1:0] directIn,
  input wire logic extClock,
  // Received SPI words
  input wire logic spiWordStrobe,
  input wire logic keepalive_toggle_bit,
  // Configuration as held by the register file, plus supply, fault and PWM pulse inputs
  input wire logic watchdog_disable_bit,
  input wire logic supplyFailEnable,
  input wire logic supplyLost,
  input wire logic faultIn,
  input wire logic [1:0] switchRequest,
  input wire logic [1:0] pwmEnable,
  input wire logic [1:0] directDisable,
  input wire logic [1:0] clockInternal,
  input wire logic [15:0] pulseWidthDuty,
  input wire logic [1:0] intPwmPulse,
  input wire logic [1:0] extPwmPulse,
  // Mode and channel state
  output logic [1:0] modeOut,
  output logic normal_state_flag,
  output logic failsafe_indicator_pin_n,
  output logic failsafe_indicator_pin_oe_n,
  output logic registersReset,
  output logic functionsReady,
  output logic [1:0] channelOn,
  output logic [1:0] channelFault,
  output logic [1:0] delaySlewSel
);
  // ==========================================================
  // Input synchronisers
  logic [2:0] syncA_reg;
  logic [2:0] syncB_reg;
  logic [2:0] syncC_reg;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      syncA_reg <= 3'h0;
      syncB_reg <= 3'h0;
      syncC_reg <= 3'h0;
    end
    else
    begin
      syncA_reg <= {wake_reset_pin, directIn}; // R24
      syncB_reg <= syncA_reg;
      syncC_reg <= syncB_reg;
    end
  end
  logic rstPin;
  logic [1:0] inPin;
  logic rstRise;
  logic [1:0] inRise;
  logic [1:0] inEdge;
  assign rstPin = syncB_reg[2];
  assign inPin = syncB_reg[1:0];
  assign rstRise = syncB_reg[2] & ~syncC_reg[2];
  assign inRise = syncB_reg[1:0] & ~syncC_reg[1:0];
  assign inEdge = syncB_reg[1:0] ^ syncC_reg[1:0];

  // ==========================================================
  // Input activity flags
  logic [TIMER_W-1:0] idleCnt_reg [2];
  logic [1:0] inActive_reg;
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_idle
    always_ff @(posedge ref_clk)
    begin
      if (!rst_n)
      begin
        idleCnt_reg[ch] <= '0;
        inActive_reg[ch] <= 1'b0;
      end
      else if (inPin[ch] || inEdge[ch])
      begin
        idleCnt_reg[ch] <= '0;
        inActive_reg[ch] <= 1'b1;
      end
      else if (idleCnt_reg[ch] >= TIMER_W'(IdleCycles))
      begin
        inActive_reg[ch] <= 1'b0; // R16
      end
      else
      begin
        idleCnt_reg[ch] <= idleCnt_reg[ch] + 1'b1;
      end
    end
  end

  // ==========================================================
  // Wake-up, keepalive watchdog and supply monitor
  logic wake;
  assign wake = rstPin | (|inActive_reg); // R2 R17
  logic [TIMER_W-1:0] wdCnt_reg;
  logic wdArmed_reg;
  logic lastKeep_reg;
  logic wdTimeout_reg;
  logic keepToggle;
  logic failsafe_reg;
  logic recovArmed_reg;
  logic recovDone;
  assign keepToggle = spiWordStrobe && (keepalive_toggle_bit != lastKeep_reg);
  // A finished recovery handshake must also clear the stale timeout, or Fail-safe re-enters.
  assign recovDone = failsafe_reg && spiWordStrobe && recovArmed_reg && !supplyLost;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || !rstPin)
    begin
      wdCnt_reg <= '0;
      wdArmed_reg <= 1'b0;
      wdTimeout_reg <= 1'b0;
    end
    else if (rstRise)
    begin
      wdCnt_reg <= '0;
      wdArmed_reg <= 1'b1;
      wdTimeout_reg <= 1'b0;
    end
    else if (watchdog_disable_bit || recovDone)
    begin
      // Held clear while disabled so that enabling it starts a fresh window.
      wdCnt_reg <= '0;
      wdTimeout_reg <= 1'b0; // R15 R22
    end
    else if (keepToggle)
    begin
      wdCnt_reg <= '0;
    end
    else if (wdArmed_reg && wdCnt_reg >= TIMER_W'(KeepaliveCycles))
    begin
      wdTimeout_reg <= 1'b1;
    end
    else if (wdArmed_reg)
    begin
      wdCnt_reg <= wdCnt_reg + 1'b1;
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      lastKeep_reg <= 1'b0;
    else if (spiWordStrobe)
      lastKeep_reg <= keepalive_toggle_bit;
  end

  // Fail-safe latch and recovery handshake.
  logic [TIMER_W-1:0] recovCnt_reg;
  logic failCause;
  assign failCause = (supplyLost && supplyFailEnable)
    || (wdTimeout_reg && !watchdog_disable_bit); // R14 R15
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || !wake)
    begin
      failsafe_reg <= 1'b0;
      recovArmed_reg <= 1'b0;
      recovCnt_reg <= '0;
    end
    else if (failCause && !failsafe_reg)
    begin
      failsafe_reg <= 1'b1;
      recovArmed_reg <= 1'b0;
      recovCnt_reg <= '0;
    end
    else if (failsafe_reg)
    begin
      if (recovDone)
      begin
        failsafe_reg <= 1'b0; // R22
        recovArmed_reg <= 1'b0;
      end
      else if (spiWordStrobe && keepalive_toggle_bit)
      begin
        recovArmed_reg <= 1'b1;
        recovCnt_reg <= '0;
      end
      else if (recovArmed_reg && recovCnt_reg >= TIMER_W'(KeepaliveCycles))
      begin
        recovArmed_reg <= 1'b0;
      end
      else if (recovArmed_reg)
      begin
        recovCnt_reg <= recovCnt_reg + 1'b1;
      end
    end
  end

  // ==========================================================
  // Mode resolution
  dsmc_mode_t mode_reg;
  dsmc_mode_t mode_next;
  always_comb
  begin
    if (!wake)
      mode_next = MODE_SLEEP; // R25
    else if (faultIn)
      mode_next = MODE_FAULT;
    else if (failsafe_reg || failCause)
      mode_next = MODE_FAILSAFE;
    else
      mode_next = MODE_NORMAL;
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      mode_reg <= MODE_SLEEP;
    else
      mode_reg <= mode_next; // R1 R12
  end

  // Settling counter after wake-up.
  logic [15:0] settleCnt_reg;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || mode_reg == MODE_SLEEP)
      settleCnt_reg <= '0;
    else if (settleCnt_reg < 16'(WAKE_SETTLE_CYC))
      settleCnt_reg <= settleCnt_reg + 1'b1; // R3
  end

  // ==========================================================
  // Channel targets
  logic spiControl;
  logic [1:0] hsOn;
  assign spiControl = rstPin && !failsafe_reg && mode_reg == MODE_NORMAL;
  always_comb
  begin
    for (int ch = 0; ch < 2; ch++)
    begin
      if (!spiControl)
        hsOn[ch] = inPin[ch]; // R18 R23
      else
        hsOn[ch] = (inPin[ch] & directDisable[ch])
          | (switchRequest[ch] & pwmEnable[ch]
             & (|pulseWidthDuty[ch*DUTY_W+DUTY_LSB +: DUTY_W])
             & (clockInternal[ch] ? intPwmPulse[ch] : extPwmPulse[ch]))
          | (switchRequest[ch] & ~pwmEnable[ch]); // R5 R6 R8 R9 R10 R11
    end
  end
  logic [1:0] chOn_reg;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      chOn_reg <= 2'h0;
    else if (mode_next == MODE_SLEEP || mode_next == MODE_FAULT)
      chOn_reg <= 2'h0;
    else
      chOn_reg <= hsOn;
  end

  assign modeOut = mode_reg;
  assign normal_state_flag = (mode_reg == MODE_NORMAL); // R4
  assign failsafe_indicator_pin_n = 1'b0;
  assign failsafe_indicator_pin_oe_n = ~(mode_reg == MODE_FAILSAFE
    || (mode_reg == MODE_FAULT && failsafe_reg)); // R21
  assign registersReset = (mode_reg == MODE_SLEEP) || failsafe_reg || (rstRise | |inRise); // R3 R21 R23
  assign functionsReady = settleCnt_reg >= 16'(WAKE_SETTLE_CYC);
  assign channelOn = chOn_reg; // R20
  assign channelFault = {2{mode_reg == MODE_FAULT}};
  assign delaySlewSel = spiControl ? 2'h3 : DEFAULT_DELAY_SLEW; // R7

  // ==========================================================
  // Checks
  property p_sleep;
    @(posedge ref_clk) disable iff (!rst_n)
    (!syncB_reg[2] && !inActive_reg[0] && !inActive_reg[1]) |=> modeOut == MODE_SLEEP;
  endproperty
  a_sleep: assert property (p_sleep) else $error("Sleep not entered."); // R17
  property p_normal;
    @(posedge ref_clk) disable iff (!rst_n)
    normal_state_flag |-> !failsafe_reg && modeOut == MODE_NORMAL;
  endproperty
  a_normal: assert property (p_normal) else $error("Normal flag wrong."); // R4
  property p_wdfs;
    @(posedge ref_clk) disable iff (!rst_n)
    (wdTimeout_reg && !watchdog_disable_bit && wake && !faultIn) |=> modeOut == MODE_FAILSAFE;
  endproperty
  a_wdfs: assert property (p_wdfs) else $error("Timeout missed Fail-safe."); // R14
  property p_fsdirect;
    @(posedge ref_clk) disable iff (!rst_n)
    (failsafe_reg && mode_next == MODE_FAILSAFE) |=> channelOn == $past(syncB_reg[1:0]);
  endproperty
  a_fsdirect: assert property (p_fsdirect) else $error("Fail-safe not direct."); // R18
  property p_fault;
    @(posedge ref_clk) disable iff (!rst_n)
    (wake && faultIn) |=> modeOut == MODE_FAULT && channelOn == 2'h0;
  endproperty
  a_fault: assert property (p_fault) else $error("Fault mode not entered."); // R25
  property p_fsoe;
    @(posedge ref_clk) disable iff (!rst_n)
    (wake && !faultIn && failCause) |=> !failsafe_indicator_pin_oe_n;
  endproperty
  a_fsoe: assert property (p_fsoe) else $error("Fail-safe pin not driven."); // R21
endmodule

//--- dsmc_host.sv
// Purpose: Host model driving the wake pin, direct inputs and SPI words.
// Assumes: Each word reaches the block as a one-cycle strobe.
// Notes: Between words the keepalive bit shows its inverse.
`timescale 1ns/10ps
module dsmc_host
(
  // Clock
  input wire logic ref_clk,
  // Pins toward the block
  output logic wakePin,
  output logic [1:0] inPins,
  output logic wordStrobe,
  output logic keepBit
);
  // ==========
  // Pin and word tasks
  initial
  begin
    wakePin = 1'h0;
    inPins = 2'h0;
    wordStrobe = 1'h0;
    keepBit = 1'h1;
  end
  task automatic set_pins(input logic w, input logic [1:0] d);
    @(posedge ref_clk);
    wakePin <= w;
    inPins <= d;
  endtask
  task automatic send_word(input logic b);
    @(posedge ref_clk);
    wordStrobe <= 1'h1;
    keepBit <= b;
    @(posedge ref_clk);
    wordStrobe <= 1'h0;
    keepBit <= ~b;
  endtask
endmodule

//--- dsmc_pkg.sv
// Purpose: Shared constants and types for the dual switch mode control block.
// Assumes: 100 MHz ref_clk.
// Notes: Long timeouts are also top-level parameters so simulation can shorten them.
package dsmc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned WAKE_SETTLE_US = 50;
  localparam int unsigned WAKE_SETTLE_CYC = (WAKE_SETTLE_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned KEEPALIVE_TIMEOUT_MS = 310;
  localparam int unsigned KEEPALIVE_TIMEOUT_CYC = (KEEPALIVE_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned INPUT_IDLE_MS = 250;
  localparam int unsigned INPUT_IDLE_CYC = (INPUT_IDLE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W = 25;
  localparam int unsigned DUTY_W = 8;
  localparam int unsigned DUTY_LSB = 0;
  localparam logic [1:0] DEFAULT_DELAY_SLEW = 2'h0;
  localparam logic [7:0] DIVIDER_RESET = 8'h00;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  typedef enum logic [1:0] {MODE_SLEEP, MODE_NORMAL, MODE_FAILSAFE, MODE_FAULT} dsmc_mode_t;
endpackage

//--- tb_dual_switch_mode_control.sv
// Purpose: Self-checking bench for the mode and channel control block.
// Assumes: Timeouts shortened to 200 cycles.
// Notes: Outputs are sampled on the falling edge.
`timescale 1ns/10ps
module tb_dual_switch_mode_control import dsmc_pkg::*;;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic wdDis = 1'h1, faultIn = 1'h0, extClk = 1'h0, sfEn = 1'h0, supLost = 1'h0;
  logic [1:0] swReq = 2'h0, pwmEn = 2'h0, dirDis = 2'h0, clkInt = 2'h0;
  logic [1:0] intPulse = 2'h0, extPulse = 2'h0, chOn, chFault, inP;
  logic [15:0] duty = 16'h0000;
  logic [1:0] mode;
  logic nFlag, fsOeN, regRst, ready, wake, strb, kBit;
  int miscompares = 0;
  int comparisons = 0;
  always #5 ref_clk = ~ref_clk;
  dsmc_host host_u (.ref_clk(ref_clk), .wakePin(wake), .inPins(inP), .wordStrobe(strb),
    .keepBit(kBit));
  dsmc_core #(.KeepaliveCycles(200), .IdleCycles(200)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .wake_reset_pin(wake), .directIn(inP), .extClock(extClk), .spiWordStrobe(strb),
    .keepalive_toggle_bit(kBit), .watchdog_disable_bit(wdDis), .supplyFailEnable(sfEn),
    .supplyLost(supLost), .faultIn(faultIn), .switchRequest(swReq), .pwmEnable(pwmEn),
    .directDisable(dirDis), .clockInternal(clkInt), .pulseWidthDuty(duty),
    .intPwmPulse(intPulse), .extPwmPulse(extPulse), .modeOut(mode),
    .normal_state_flag(nFlag), .failsafe_indicator_pin_n(), .failsafe_indicator_pin_oe_n(fsOeN),
    .registersReset(regRst), .functionsReady(ready), .channelOn(chOn),
    .channelFault(chFault), .delaySlewSel());
  // ==========
  // Shared tasks
  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      $display("ERROR %s expected %0h seen %0h", n, e, s);
      miscompares++;
    end
  endtask
  task automatic wait_mode(input dsmc_mode_t m, input int lim);
    int i;
    @(negedge ref_clk);
    for (i = 0; i < lim && mode !== m; i++)
      @(negedge ref_clk);
    check("mode", {30'h0, mode}, {30'h0, m});
    if (mode !== m)
      give_verdict();
  endtask
  // ==========
  // Scenarios
  task automatic t_wake();
    int i;
    host_u.set_pins(1'h1, 2'h0);
    wait_mode(MODE_NORMAL, 8);
    check("normal flag", nFlag, 1'h1);
    check("ready early", ready, 1'h0);
    for (i = 0; i < WAKE_SETTLE_CYC + 10 && ready !== 1'h1; i++)
      @(negedge ref_clk);
    check("settle", i, WAKE_SETTLE_CYC);
    check("ready", ready, 1'h1);
    if (ready !== 1'h1)
      give_verdict();
  endtask
  task automatic t_watchdog();
    int k;
    @(posedge ref_clk);
    wdDis <= 1'h0;
    for (k = 0; k < 4; k++)
    begin
      host_u.send_word(k[0]);
      repeat (120) @(negedge ref_clk);
      check("kept", {30'h0, mode}, {30'h0, MODE_NORMAL});
    end
    wait_mode(MODE_FAILSAFE, 300);
    check("flag off", nFlag, 1'h0);
    check("fs pin", fsOeN, 1'h0);
    check("regs reset", regRst, 1'h1);
    @(posedge ref_clk);
    swReq <= 2'h3;
    repeat (4) @(negedge ref_clk);
    check("spi ignored", chOn, 2'h0);
    host_u.send_word(1'h1);
    host_u.send_word(1'h0);
    wait_mode(MODE_NORMAL, 10);
    check("fs released", fsOeN, 1'h1);
    @(posedge ref_clk);
    wdDis <= 1'h1;
    swReq <= 2'h0;
    repeat (400) @(negedge ref_clk);
    check("wd off", {30'h0, mode}, {30'h0, MODE_NORMAL});
    @(posedge ref_clk);
    sfEn <= 1'h1;
    supLost <= 1'h1;
    wait_mode(MODE_FAILSAFE, 4);
    check("supply fs pin", fsOeN, 1'h0);
    @(posedge ref_clk);
    supLost <= 1'h0;
    host_u.send_word(1'h1);
    host_u.send_word(1'h0);
    wait_mode(MODE_NORMAL, 10);
  endtask
  task automatic t_chan();
    host_u.set_pins(1'h1, 2'h1);
    dirDis <= 2'h1;
    swReq <= 2'h2;
    repeat (6) @(negedge ref_clk);
    check("direct and req", chOn, 2'h3);
    @(posedge ref_clk);
    pwmEn <= 2'h2;
    clkInt <= 2'h2;
    duty <= 16'h8000;
    intPulse <= 2'h2;
    repeat (4) @(negedge ref_clk);
    check("pwm high", chOn, 2'h3);
    @(posedge ref_clk);
    intPulse <= 2'h0;
    repeat (4) @(negedge ref_clk);
    check("pwm low", chOn, 2'h1);
    @(posedge ref_clk);
    duty <= 16'h00FF;
    intPulse <= 2'h2;
    repeat (4) @(negedge ref_clk);
    check("duty zero", chOn, 2'h1);
    @(posedge ref_clk);
    duty <= 16'h8000;
    clkInt <= 2'h0;
    intPulse <= 2'h0;
    extPulse <= 2'h2;
    repeat (4) @(negedge ref_clk);
    check("ext high", chOn, 2'h3);
    @(posedge ref_clk);
    extPulse <= 2'h0;
    repeat (4) @(negedge ref_clk);
    check("ext low", chOn, 2'h1);
  endtask
  task automatic t_fault_sleep();
    @(posedge ref_clk);
    faultIn <= 1'h1;
    wait_mode(MODE_FAULT, 4);
    check("fault", chFault, 2'h3);
    check("fault off", chOn, 2'h0);
    @(posedge ref_clk);
    faultIn <= 1'h0;
    wait_mode(MODE_NORMAL, 4);
    host_u.set_pins(1'h0, 2'h0);
    wait_mode(MODE_SLEEP, 300);
    check("sleep off", chOn, 2'h0);
    host_u.set_pins(1'h0, 2'h2);
    wait_mode(MODE_NORMAL, 8);
  endtask
  // ==========
  // Main sequence
  initial
  begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'h1;
    t_wake();
    t_watchdog();
    t_chan();
    t_fault_sleep();
    give_verdict();
  end
endmodule
